/* File: rtl/csf_flags.sv */
// status flags and operand range checker of an 8-bit cpu
// assumes one op request a cycle and apb master on core_clk
//
// Chosen here: the APB register port.
`timescale 1ns/10ps
`include "csf_map.svh"

module csf_flags (
    // clock and reset
    input  wire logic                 core_clk,
    input  wire logic                 nrst,
    // apb slave
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [`CSF_AW-1:0]   paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    // alu request
    input  wire csf_pkg::csf_req_t    req,
    output logic      [7:0]           result_reg,
    output logic                      result_we_reg,
    // flags
    output logic      [7:0]           flags_reg,
    output logic      [3:0]           cond_flags_reg,
    output logic                      irq_block_reg,
    output logic                      fast_ret_reg,
    output logic                      bank_sel_reg,
    // operand check
    input  wire csf_pkg::csf_opnd_t   opnd,
    output logic                      opnd_done_reg,
    output logic                      opnd_legal_reg,
    output logic      [15:0]          opnd_addr_reg
);

    // =====================================
    // flag handling table
    function automatic csf_pkg::csf_acts_t acts(input csf_pkg::csf_op_t op);
        csf_pkg::csf_acts_t t;
        t = '{c: csf_pkg::CSF_FA_KEEP, z: csf_pkg::CSF_FA_KEEP,
              s: csf_pkg::CSF_FA_KEEP, v: csf_pkg::CSF_FA_KEEP,
              d: csf_pkg::CSF_FA_KEEP, h: csf_pkg::CSF_FA_KEEP};
        unique case (op)
            csf_pkg::CSF_OP_ADD, csf_pkg::CSF_OP_ADC,
            csf_pkg::CSF_OP_SUB, csf_pkg::CSF_OP_SBC: begin
                t = '{c: csf_pkg::CSF_FA_UPD, z: csf_pkg::CSF_FA_UPD,
                      s: csf_pkg::CSF_FA_UPD, v: csf_pkg::CSF_FA_UPD,
                      d: csf_pkg::CSF_FA_UPD, h: csf_pkg::CSF_FA_UPD};
            end
            csf_pkg::CSF_OP_AND, csf_pkg::CSF_OP_OR,
            csf_pkg::CSF_OP_XOR, csf_pkg::CSF_OP_TEST: begin
                t.z = csf_pkg::CSF_FA_UPD;
                t.s = csf_pkg::CSF_FA_UPD;
                t.v = csf_pkg::CSF_FA_ZERO;
            end
            csf_pkg::CSF_OP_ROL, csf_pkg::CSF_OP_ROLC,
            csf_pkg::CSF_OP_ROR, csf_pkg::CSF_OP_RORC,
            csf_pkg::CSF_OP_SRA: begin
                t.c = csf_pkg::CSF_FA_UPD;
                t.z = csf_pkg::CSF_FA_UPD;
                t.s = csf_pkg::CSF_FA_UPD;
                t.v = (op == csf_pkg::CSF_OP_SRA) ? csf_pkg::CSF_FA_ZERO
                                                  : csf_pkg::CSF_FA_UPD;
            end
            csf_pkg::CSF_OP_DEC_ADJ: begin
                t.c = csf_pkg::CSF_FA_UPD;
                t.z = csf_pkg::CSF_FA_UPD;
                t.s = csf_pkg::CSF_FA_UPD;
                t.v = csf_pkg::CSF_FA_UNDEF;
                t.h = csf_pkg::CSF_FA_UNDEF;
            end
            csf_pkg::CSF_OP_SETC: t.c = csf_pkg::CSF_FA_ONE;
            csf_pkg::CSF_OP_CLRC: t.c = csf_pkg::CSF_FA_ZERO;
            csf_pkg::CSF_OP_CPLC: t.c = csf_pkg::CSF_FA_UPD;
            default: ;
        endcase
        return t;
    endfunction : acts

    // undefined flags keep their old value
    function automatic logic app(input csf_pkg::csf_fact_t f, input logic old_v, input logic calc);
        unique case (f)
            csf_pkg::CSF_FA_ZERO:  app = 1'b0;
            csf_pkg::CSF_FA_ONE:   app = 1'b1;
            csf_pkg::CSF_FA_UPD:   app = calc;
            csf_pkg::CSF_FA_KEEP:  app = old_v;
            csf_pkg::CSF_FA_UNDEF: app = old_v;
        endcase
    endfunction : app

    // =====================================
    // alu flag calculation
    logic [8:0] r9;
    logic       ci, hc, vc, dc, cc, wr;
    logic [7:0] fix;
    csf_pkg::csf_acts_t ac;
    logic [7:0] base, f_nx;
    logic       apb_wr;
    logic       apb_set;

    always_comb begin
        ci  = 1'b0;
        hc  = 1'b0;
        vc  = 1'b0;
        dc  = flags_reg[`CSF_D];
        fix = 8'h00;
        r9  = {1'b0, req.a};
        wr  = 1'b1;
        unique case (req.op)
            csf_pkg::CSF_OP_ADD, csf_pkg::CSF_OP_ADC: begin
                ci = (req.op == csf_pkg::CSF_OP_ADC) & flags_reg[`CSF_C];
                r9 = {1'b0, req.a} + {1'b0, req.b} + {8'h00, ci};
                hc = ({1'b0, req.a[3:0]} + {1'b0, req.b[3:0]} + {4'h0, ci}) > 5'h0f;
                vc = (req.a[7] == req.b[7]) && (r9[7] != req.a[7]);
                dc = 1'b0;
            end
            csf_pkg::CSF_OP_SUB, csf_pkg::CSF_OP_SBC: begin
                ci = (req.op == csf_pkg::CSF_OP_SBC) & flags_reg[`CSF_C];
                r9 = {1'b0, req.a} - {1'b0, req.b} - {8'h00, ci};
                hc = {1'b0, req.a[3:0]} < ({1'b0, req.b[3:0]} + {4'h0, ci});
                vc = (req.a[7] != req.b[7]) && (r9[7] != req.a[7]);
                dc = 1'b1;
            end
            csf_pkg::CSF_OP_AND: r9 = {1'b0, req.a & req.b};
            csf_pkg::CSF_OP_OR:  r9 = {1'b0, req.a | req.b};
            csf_pkg::CSF_OP_XOR: r9 = {1'b0, req.a ^ req.b};
            csf_pkg::CSF_OP_TEST: begin
                r9 = {1'b0, req.a & req.b};
                wr = 1'b0;
            end
            // carry holds the bit shifted out
            csf_pkg::CSF_OP_ROL:  r9 = {req.a[7], req.a[6:0], req.a[7]};
            csf_pkg::CSF_OP_ROLC: r9 = {req.a[7], req.a[6:0], flags_reg[`CSF_C]};
            csf_pkg::CSF_OP_ROR:  r9 = {req.a[0], req.a[0], req.a[7:1]};
            csf_pkg::CSF_OP_RORC: r9 = {req.a[0], flags_reg[`CSF_C], req.a[7:1]};
            csf_pkg::CSF_OP_SRA:  r9 = {req.a[0], req.a[7], req.a[7:1]};
            csf_pkg::CSF_OP_DEC_ADJ: begin
                if (!flags_reg[`CSF_D]) begin
                    fix[7:4] = (flags_reg[`CSF_C] || req.a > `CSF_BCD_TOP) ? 4'h6 : 4'h0;
                    fix[3:0] = (flags_reg[`CSF_H] || req.a[3:0] > `CSF_NIB_TOP) ? 4'h6 : 4'h0;
                    r9 = {fix[7:4] != 4'h0, req.a + fix};
                end else begin
                    fix[7:4] = flags_reg[`CSF_C] ? 4'h6 : 4'h0;
                    fix[3:0] = flags_reg[`CSF_H] ? 4'h6 : 4'h0;
                    r9 = {flags_reg[`CSF_C], req.a - fix};
                end
            end
            default: wr = 1'b0;
        endcase
        if (req.op inside {csf_pkg::CSF_OP_ROL, csf_pkg::CSF_OP_ROLC,
                           csf_pkg::CSF_OP_ROR, csf_pkg::CSF_OP_RORC})
            vc = r9[7] != req.a[7];
        cc = (req.op == csf_pkg::CSF_OP_CPLC) ? ~flags_reg[`CSF_C] : r9[8];
    end

    // =====================================
    // next flags
    assign apb_wr  = psel && penable && pready && pwrite;
    assign apb_set = apb_wr && (paddr == `CSF_FLAGS_ADDR);

    always_comb begin
        ac   = acts(req.op);
        // result written into flags is overridden by flag updates
        base = (req.valid && req.dst_flags && wr) ? r9[7:0] : flags_reg;
        f_nx = flags_reg;
        if (req.valid) begin
            f_nx             = base;
            f_nx[`CSF_C]     = app(ac.c, base[`CSF_C], cc);
            f_nx[`CSF_Z]     = app(ac.z, base[`CSF_Z], r9[7:0] == 8'h00);
            f_nx[`CSF_S]     = app(ac.s, base[`CSF_S], r9[7]);
            f_nx[`CSF_V]     = app(ac.v, base[`CSF_V], vc);
            f_nx[`CSF_D]     = app(ac.d, base[`CSF_D], dc);
            f_nx[`CSF_H]     = app(ac.h, base[`CSF_H], hc);
            if (req.op == csf_pkg::CSF_OP_FIRQ)
                f_nx[`CSF_FIS] = 1'b1;
            if (req.op == csf_pkg::CSF_OP_IRQ_RET)
                f_nx[`CSF_FIS] = 1'b0;
            if (req.op == csf_pkg::CSF_OP_BANK0)
                f_nx[`CSF_BA]  = 1'b0;
            if (req.op == csf_pkg::CSF_OP_BANK1)
                f_nx[`CSF_BA]  = 1'b1;
        end else if (apb_set) begin
            f_nx = pwdata[7:0];
        end
    end

    // =====================================
    // flag registers
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            flags_reg      <= `CSF_FLAGS_RST;
            cond_flags_reg <= 4'h0;
            irq_block_reg  <= 1'b0;
            bank_sel_reg   <= 1'b0;
        end else begin
            flags_reg      <= f_nx;
            cond_flags_reg <= f_nx[7:4];
            irq_block_reg  <= f_nx[`CSF_FIS];
            bank_sel_reg   <= f_nx[`CSF_BA];
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            fast_ret_reg  <= 1'b0;
            result_reg    <= 8'h00;
            result_we_reg <= 1'b0;
        end else begin
            fast_ret_reg  <= req.valid && req.op == csf_pkg::CSF_OP_IRQ_RET
                             && flags_reg[`CSF_FIS];
            result_we_reg <= req.valid && wr;
            if (req.valid && wr)
                result_reg <= r9[7:0];
        end
    end

    // =====================================
    // operand range checker
    logic        ok;
    logic [15:0] ad;
    logic [15:0] sx;

    always_comb begin
        sx = {{8{opnd.val[7]}}, opnd.val[7:0]};
        ad = opnd.val;
        unique case (opnd.mode)
            csf_pkg::CSF_MD_WREG:  ok = opnd.val <= `CSF_WREG_MAX;
            csf_pkg::CSF_MD_WBIT:  ok = opnd.val <= `CSF_WBIT_MAX;
            csf_pkg::CSF_MD_WPAIR: ok = opnd.val <= `CSF_WPAIR_MAX && !opnd.val[0];
            csf_pkg::CSF_MD_REG:   ok = opnd.val <= `CSF_BYTE_MAX;
            csf_pkg::CSF_MD_PAIR:  ok = opnd.val <= `CSF_PAIR_MAX && !opnd.val[0];
            csf_pkg::CSF_MD_SHORT_IDX: begin
                ok = opnd.val <= `CSF_BYTE_MAX;
                ad = opnd.base + sx;
            end
            csf_pkg::CSF_MD_LONG_IDX: begin
                ok = 1'b1;
                ad = opnd.base + opnd.val;
            end
            csf_pkg::CSF_MD_REL: begin
                ok = opnd.val <= `CSF_BYTE_MAX;
                ad = opnd.base + sx;
            end
            csf_pkg::CSF_MD_IND_CALL: ok = opnd.val <= `CSF_PAIR_MAX && !opnd.val[0];
            csf_pkg::CSF_MD_IMM8:  ok = opnd.val <= `CSF_BYTE_MAX;
            csf_pkg::CSF_MD_IMM16: ok = 1'b1;
            default:               ok = 1'b0;
        endcase
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            opnd_done_reg  <= 1'b0;
            opnd_legal_reg <= 1'b0;
            opnd_addr_reg  <= 16'h0000;
        end else begin
            opnd_done_reg <= opnd.valid;
            if (opnd.valid) begin
                opnd_legal_reg <= ok;
                opnd_addr_reg  <= ad;
            end
        end
    end

    // =====================================
    // apb slave, answers in the first access cycle
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && paddr != `CSF_FLAGS_ADDR
                       && paddr != `CSF_RESULT_ADDR;
            if (psel && !penable) begin
                if (paddr == `CSF_FLAGS_ADDR && !pwrite)
                    prdata <= {24'h000000, flags_reg};
                else if (paddr == `CSF_RESULT_ADDR && !pwrite)
                    prdata <= {24'h000000, result_reg};
                else
                    prdata <= 32'h0000_0000;
            end
        end
    end

    // =====================================
    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    logic signed [9:0] ssum;
    assign ssum = 10'($signed(req.a)) + 10'($signed(req.b));

    sequence s_add;
        req.valid && req.op == csf_pkg::CSF_OP_ADD && !req.dst_flags;
    endsequence
    sequence s_setup;
        psel && !penable;
    endsequence

    AST_V_ADD: assert property (s_add |=> flags_reg[`CSF_V] == $past(ssum > 10'sd127 || ssum < -10'sd128))
        else $error("overflow flag wrong after add");
    AST_V_LOGIC: assert property (req.valid && req.op inside {csf_pkg::CSF_OP_AND,
        csf_pkg::CSF_OP_OR, csf_pkg::CSF_OP_XOR} && !req.dst_flags |=> !flags_reg[`CSF_V])
        else $error("overflow not cleared by logic op");
    AST_D_KIND: assert property (s_add ##2 (req.valid && req.op == csf_pkg::CSF_OP_SUB
        && !req.dst_flags) |-> !flags_reg[`CSF_D] ##1 flags_reg[`CSF_D])
        else $error("decimal flag does not track add then sub");
    AST_H_ADD: assert property (s_add |=> flags_reg[`CSF_H] ==
        $past(({1'b0, req.a[3:0]} + {1'b0, req.b[3:0]}) > 5'h0f))
        else $error("half carry wrong after add");
    AST_FIS: assert property (req.valid && req.op == csf_pkg::CSF_OP_FIRQ
        |=> flags_reg[`CSF_FIS] && irq_block_reg)
        else $error("fast irq entry did not block");
    AST_FRET: assert property (req.valid && req.op == csf_pkg::CSF_OP_IRQ_RET && irq_block_reg
        |=> fast_ret_reg && !irq_block_reg)
        else $error("fast return not taken");
    AST_BANK: assert property (req.valid && req.op == csf_pkg::CSF_OP_BANK1
        |=> bank_sel_reg && flags_reg[`CSF_BA])
        else $error("bank one not selected");
    AST_COND: assert property (cond_flags_reg == flags_reg[7:4])
        else $error("condition flags out of step");
    AST_WREG: assert property (opnd.valid && opnd.mode == csf_pkg::CSF_MD_WREG
        |=> opnd_legal_reg == ($past(opnd.val) < 16'h0010))
        else $error("working register range wrong");
    AST_REL: assert property (opnd.valid && opnd.mode == csf_pkg::CSF_MD_REL
        |=> opnd_addr_reg == 16'($past(opnd.base) + {{8{$past(opnd.val[7])}}, $past(opnd.val[7:0])}))
        else $error("relative target wrong");
    AST_APB: assert property (s_setup |=> pready ##1 !pready)
        else $error("apb answer timing wrong");

endmodule : csf_flags

/* File: shared/csf_map.svh */
// constants of the cpu status flag block
// assumes an apb slave with 32-bit data, one word a register
//
// Operation
// - overflow set when result leaves -128..+127
// - logic operations clear overflow
// - decimal flag records last bcd kind, untestable
// - half carry from bit 3 or borrow bit 4
// - decimal adjust uses half carry and decimal
// - fast irq status set on entry, cleared on return
// - fast irq status blocks irqs, fast return
// - bank flag: bank zero clears, bank one sets
// - flags register mapped at d5 hex
// - working registers 0..15, working bit operands 0..127
// - pairs even 0..254, working pairs even 0..14
// - general registers 0..255 or working register
// - short index adds signed byte offset
// - long index adds unsigned 16-bit offset
// - relative target is next address plus displacement
// - indirect call addresses even 0..254
// - immediates 0..255, long immediates 0..65535
// - each flag zeroed, set, updated, kept, undefined
// - carry from msb, or last bit shifted out
// - zero flag set on zero result
// - sign flag copies result msb
`ifndef CSF_MAP_SVH
`define CSF_MAP_SVH

// =====================================
// register map
`define CSF_AW          12
`define CSF_FLAGS_IDX   10'h0d5
`define CSF_RESULT_IDX  10'h0d6
`define CSF_FLAGS_ADDR  {`CSF_FLAGS_IDX, 2'b00}
`define CSF_RESULT_ADDR {`CSF_RESULT_IDX, 2'b00}
`define CSF_FLAGS_RST   8'h00

// =====================================
// flag bit positions
`define CSF_C   7
`define CSF_Z   6
`define CSF_S   5
`define CSF_V   4
`define CSF_D   3
`define CSF_H   2
`define CSF_FIS 1
`define CSF_BA  0

// =====================================
// operand limits
`define CSF_WREG_MAX  16'h000f
`define CSF_WBIT_MAX  16'h007f
`define CSF_WPAIR_MAX 16'h000e
`define CSF_BYTE_MAX  16'h00ff
`define CSF_PAIR_MAX  16'h00fe
`define CSF_BCD_FIX   8'h06
`define CSF_BCD_TOP   8'h99
`define CSF_NIB_TOP   4'h9

`endif

/* File: shared/csf_pkg.sv */
// types of the cpu status flag block
// assumes csf_map.svh for all numeric constants
package csf_pkg;

    // =====================================
    // operations that touch the flags
    typedef enum logic [4:0] {
        CSF_OP_NOP, CSF_OP_ADD, CSF_OP_ADC, CSF_OP_SUB, CSF_OP_SBC,
        CSF_OP_AND, CSF_OP_OR, CSF_OP_XOR, CSF_OP_TEST,
        CSF_OP_ROL, CSF_OP_ROLC, CSF_OP_ROR, CSF_OP_RORC, CSF_OP_SRA,
        CSF_OP_DEC_ADJ, CSF_OP_BANK0, CSF_OP_BANK1,
        CSF_OP_SETC, CSF_OP_CLRC, CSF_OP_CPLC,
        CSF_OP_FIRQ, CSF_OP_IRQ_RET
    } csf_op_t;

    // =====================================
    // per-flag handling
    typedef enum logic [2:0] {
        CSF_FA_ZERO, CSF_FA_ONE, CSF_FA_UPD, CSF_FA_KEEP, CSF_FA_UNDEF
    } csf_fact_t;

    typedef struct packed {
        csf_fact_t c, z, s, v, d, h;
    } csf_acts_t;

    // =====================================
    // operand encodings
    typedef enum logic [3:0] {
        CSF_MD_WREG, CSF_MD_WBIT, CSF_MD_WPAIR, CSF_MD_REG, CSF_MD_PAIR,
        CSF_MD_SHORT_IDX, CSF_MD_LONG_IDX, CSF_MD_REL,
        CSF_MD_IND_CALL, CSF_MD_IMM8, CSF_MD_IMM16
    } csf_mode_t;

    // =====================================
    // carriers
    typedef struct packed {
        logic       valid;
        csf_op_t    op;
        logic [7:0] a;
        logic [7:0] b;
        logic       dst_flags;
    } csf_req_t;

    typedef struct packed {
        logic        valid;
        csf_mode_t   mode;
        logic [15:0] val;
        logic [15:0] base;
    } csf_opnd_t;

endpackage : csf_pkg

/* File: verification/csf_flags_bench.sv */
// self-checking bench of the cpu status flag block
// assumes csf_flags, csf_pkg and csf_map.svh, one clock core_clk
`timescale 1ns/10ps
`include "csf_map.svh"

module csf_flags_bench;
    // =====================================
    // signals
    logic                 core_clk, nrst, psel, penable, pwrite, pready, pslverr, se;
    logic [`CSF_AW-1:0]   paddr;
    logic [31:0]          pwdata, prdata, rd, w;
    csf_pkg::csf_req_t    req;
    csf_pkg::csf_opnd_t   opnd;
    csf_pkg::csf_op_t     o;
    csf_pkg::csf_mode_t   md;
    logic [7:0]           result_reg, flags_reg, ef, a, b, r;
    logic [3:0]           cond_flags_reg;
    logic                 result_we_reg, irq_block_reg, fast_ret_reg, bank_sel_reg;
    logic                 opnd_done_reg, opnd_legal_reg;
    logic [15:0]          opnd_addr_reg, bs;
    logic [15:0]          vals [0:8];
    int                   err_count, tests_run;

    csf_flags dut_u (.core_clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .req, .result_reg, .result_we_reg, .flags_reg, .cond_flags_reg, .irq_block_reg,
        .fast_ret_reg, .bank_sel_reg, .opnd, .opnd_done_reg, .opnd_legal_reg, .opnd_addr_reg);

    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    // =====================================
    // checks and closing
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic end_of_test;
        $display("mismatches %0d comparisons %0d", err_count, tests_run);
        if (err_count == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_of_test

    // =====================================
    // drivers
    task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] wd,
                       output logic [31:0] q, output logic e);
        int n;
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= ad;
        pwdata <= wd;
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            err_count++;
            end_of_test();
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic op(input csf_pkg::csf_op_t x, input logic [7:0] p, input logic [7:0] s, input logic d);
        @(posedge core_clk);
        req <= '{1'b1, x, p, s, d};
        @(posedge core_clk);
        req.valid <= 1'b0;
        #1;
    endtask : op

    // =====================================
    // expectations
    function automatic logic [7:0] res(input csf_pkg::csf_op_t x, input logic [7:0] p, input logic [7:0] s);
        case (x)
            csf_pkg::CSF_OP_ADD: return p + s;
            csf_pkg::CSF_OP_SUB: return p - s;
            csf_pkg::CSF_OP_AND: return p & s;
            csf_pkg::CSF_OP_OR:  return p | s;
            default:             return p ^ s;
        endcase
    endfunction : res

    function automatic logic [7:0] fl(input csf_pkg::csf_op_t x, input logic [7:0] p, input logic [7:0] s,
                                      input logic [7:0] f);
        logic [8:0] t;
        logic [7:0] q;
        q = f;
        t = {1'b0, p} - {1'b0, s};
        if (x == csf_pkg::CSF_OP_ADD) begin
            t = {1'b0, p} + {1'b0, s};
            q[7] = t[8];
            q[4] = (p[7] == s[7]) && (t[7] != p[7]);
            q[3] = 1'b0;
            q[2] = ({1'b0, p[3:0]} + {1'b0, s[3:0]}) > 5'h0f;
        end else if (x == csf_pkg::CSF_OP_SUB) begin
            q[7] = t[8];
            q[4] = (p[7] != s[7]) && (t[7] != p[7]);
            q[3] = 1'b1;
            q[2] = p[3:0] < s[3:0];
        end else begin
            q[4] = 1'b0;
        end
        q[6] = res(x, p, s) == 8'h00;
        q[5] = res(x, p, s) >> 7;
        return q;
    endfunction : fl

    function automatic logic lg(input csf_pkg::csf_mode_t m, input logic [15:0] v);
        case (m)
            csf_pkg::CSF_MD_WREG:  return v <= 16'h000f;
            csf_pkg::CSF_MD_WBIT:  return v <= 16'h007f;
            csf_pkg::CSF_MD_WPAIR: return v <= 16'h000e && !v[0];
            csf_pkg::CSF_MD_PAIR, csf_pkg::CSF_MD_IND_CALL: return v <= 16'h00fe && !v[0];
            csf_pkg::CSF_MD_LONG_IDX, csf_pkg::CSF_MD_IMM16: return 1'b1;
            default: return v <= 16'h00ff;
        endcase
    endfunction : lg

    // =====================================
    // main sequence
    initial begin
        {nrst, psel, penable, pwrite, paddr, pwdata, req, opnd} = '0;
        err_count = 0;
        tests_run = 0;
        vals = '{16'h000e, 16'h000f, 16'h0010, 16'h007f, 16'h0080, 16'h00fe, 16'h00ff, 16'h0100, 16'hfff1};
        void'($urandom(87875));
        repeat (4) @(posedge core_clk);
        nrst <= 1'b1;
        apb(1'b0, `CSF_FLAGS_ADDR, 32'h0, rd, se);
        chk(rd, `CSF_FLAGS_RST);
        apb(1'b1, 12'h350, 32'hffffffff, rd, se);
        chk(se, 1'b1);
        w = $urandom;
        apb(1'b1, `CSF_FLAGS_ADDR, w, rd, se);
        apb(1'b0, `CSF_FLAGS_ADDR, 32'h0, rd, se);
        chk(rd, {24'h0, w[7:0]});
        ef = w[7:0];
        for (int i = 0; i < 300; i++) begin
            o = csf_pkg::csf_op_t'((i % 3 == 2) ? 5'd5 + 5'($urandom % 3) : 5'd1 + 5'd2 * 5'($urandom % 2));
            {a, b} = 16'($urandom);
            if (i < 2) begin
                {o, a, b} = (i == 0) ? {csf_pkg::CSF_OP_ADD, 16'h7f01} : {csf_pkg::CSF_OP_SUB, 16'h8001};
            end
            op(o, a, b, 1'b0);
            ef = fl(o, a, b, ef);
            chk(flags_reg, ef);
            chk(cond_flags_reg, ef[7:4]);
            chk({result_we_reg, result_reg}, {1'b1, res(o, a, b)});
        end
        {a, b} = 16'($urandom);
        op(csf_pkg::CSF_OP_AND, a, b, 1'b1);
        r = a & b;
        ef = {r[7], r == 8'h00, r[7], 1'b0, r[3:0]};
        chk(flags_reg, ef);
        op(csf_pkg::CSF_OP_FIRQ, 8'h00, 8'h00, 1'b0);
        ef[1] = 1'b1;
        chk(flags_reg, ef);
        chk(irq_block_reg, 1'b1);
        op(csf_pkg::CSF_OP_IRQ_RET, 8'h00, 8'h00, 1'b0);
        ef[1] = 1'b0;
        chk({fast_ret_reg, irq_block_reg, flags_reg}, {2'b10, ef});
        op(csf_pkg::CSF_OP_IRQ_RET, 8'h00, 8'h00, 1'b0);
        chk(fast_ret_reg, 1'b0);
        op(csf_pkg::CSF_OP_BANK1, 8'h00, 8'h00, 1'b0);
        ef[0] = 1'b1;
        chk({bank_sel_reg, flags_reg}, {1'b1, ef});
        op(csf_pkg::CSF_OP_BANK0, 8'h00, 8'h00, 1'b0);
        ef[0] = 1'b0;
        chk({bank_sel_reg, flags_reg}, {1'b0, ef});
        op(csf_pkg::CSF_OP_ADD, 8'h15, 8'h27, 1'b0);
        op(csf_pkg::CSF_OP_DEC_ADJ, result_reg, 8'h00, 1'b0);
        chk(result_reg, 8'h42);
        op(csf_pkg::CSF_OP_SUB, 8'h42, 8'h15, 1'b0);
        op(csf_pkg::CSF_OP_DEC_ADJ, 8'h2d, 8'h00, 1'b0);
        chk(result_reg, 8'h27);
        apb(1'b0, `CSF_RESULT_ADDR, 32'h0, rd, se);
        chk({se, rd}, {1'b0, 32'h0000_0027});
        for (int m = 0; m < 11; m++) begin
            for (int k = 0; k < 9; k++) begin
                md = csf_pkg::csf_mode_t'(4'(m));
                bs = 16'($urandom);
                @(posedge core_clk);
                opnd <= '{1'b1, md, vals[k], bs};
                @(posedge core_clk);
                opnd.valid <= 1'b0;
                #1;
                chk({opnd_done_reg, opnd_legal_reg}, {1'b1, lg(md, vals[k])});
                if (md == csf_pkg::CSF_MD_LONG_IDX) begin
                    chk(opnd_addr_reg, 16'(bs + vals[k]));
                end else if (md == csf_pkg::CSF_MD_SHORT_IDX || md == csf_pkg::CSF_MD_REL) begin
                    chk(opnd_addr_reg, 16'(bs + {{8{vals[k][7]}}, vals[k][7:0]}));
                end
            end
        end
        end_of_test();
    end
endmodule : csf_flags_bench
